// ==== rtl/inq_verify_pkg.sv ====
// Package: constants and types for the inquiry and verify command block
package inq_verify_pkg;
   localparam logic [7:0] OP_INQUIRY = 8'h12;
   localparam logic [7:0] OP_VERIFY = 8'h13;
   localparam logic [7:0] STATUS_GOOD = 8'h00;
   localparam logic [7:0] STATUS_CHECK = 8'h02;
   localparam logic [3:0] SENSE_NONE = 4'h0;
   localparam logic [3:0] SENSE_MEDIA = 4'h3;
   localparam logic [3:0] SENSE_HARDWARE = 4'h4;
   localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
   localparam logic [7:0] SENSE_FLAGS_EOT = 8'h40;
   localparam logic [7:0] SENSE_FLAGS_FILEMARK = 8'h80;
   localparam logic [7:0] SENSE_FLAGS_NONE = 8'h00;
   localparam logic [5:0] INQ_MAX_LEN = 6'd36;
   localparam logic [7:0] ADDITIONAL_LENGTH = 8'h1F;
   localparam logic [5:0] ADDITIONAL_FIRST_OFFSET = 6'h05;
   localparam logic [2:0] EUROPEAN_STANDARD_CLAIM = 3'h0;
   localparam logic [2:0] BUS_STANDARD_REVISION = 3'h1;
   localparam int EUROPEAN_CLAIM_LSB = 3;
   localparam int BUS_REVISION_LSB = 0;
   localparam int BYTE_COMPARE_BIT = 1;
   localparam int FIXED_BLOCK_BIT = 0;
   localparam logic [7:0] DEVICE_TYPE_SEQUENTIAL = 8'h01;
   localparam logic [7:0] REMOVABLE_BYTE = 8'h80;
   localparam logic [5:0] VENDOR_FIRST = 6'd8;
   localparam logic [5:0] PRODUCT_FIRST = 6'd16;
   localparam logic [5:0] REVISION_FIRST = 6'd32;
   localparam logic [5:0] INQ_LAST = 6'd35;
   localparam logic [7:0] ASCII_SPACE = 8'h20;
   localparam logic [7:0] ASCII_DASH = 8'h2D;
   localparam logic [23:0] COUNT_RESET = 24'h000000;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [7:0] byte3;
      logic [7:0] byte4;
      logic [7:0] byte5;
   } cdb_type;

   typedef struct packed {
      logic crcGood;
      logic crcBad;
      logic filemark;
      logic endOfTape;
   } block_result_type;

   typedef struct packed {
      logic [7:0] status;
      logic [3:0] senseKey;
      logic [7:0] senseFlags;
   } completion_type;
endpackage

// ==== rtl/inquiry_rom.sv ====
// Inquiry response byte table
`timescale 1ns/1ps
module inquiry_rom #(
   parameter logic [63:0] VENDOR_TEXT = 64'h5441_5045_4455_5620,
   parameter logic [127:0] PRODUCT_TEXT = 128'h5441_5045_2D44_5249_5645_2031_3233_3435,
   parameter logic [23:0] REVISION_DIGITS = 24'h303031
) (
   input wire logic [5:0] index,
   output logic [7:0] dataByte
);
   logic [4:0] vendOff;
   logic [4:0] prodOff;
   logic [4:0] revOff;

   always_comb begin
      vendOff = 5'(index - inq_verify_pkg::VENDOR_FIRST);
      prodOff = 5'(index - inq_verify_pkg::PRODUCT_FIRST);
      revOff = 5'(index - inq_verify_pkg::REVISION_FIRST);
      dataByte = 8'h00;
      if (index == 6'd0) begin
         dataByte = inq_verify_pkg::DEVICE_TYPE_SEQUENTIAL;
      end else if (index == 6'd1) begin
         dataByte = inq_verify_pkg::REMOVABLE_BYTE;
      end else if (index == 6'd2) begin
         dataByte = {2'b00, inq_verify_pkg::EUROPEAN_STANDARD_CLAIM,
                     inq_verify_pkg::BUS_STANDARD_REVISION}; // RULE1 RULE2
      end else if (index == 6'd4) begin
         dataByte = inq_verify_pkg::ADDITIONAL_LENGTH; // RULE3 RULE4
      end else if (index >= inq_verify_pkg::VENDOR_FIRST &&
                   index < inq_verify_pkg::PRODUCT_FIRST) begin
         dataByte = VENDOR_TEXT[8'(63 - 8 * vendOff) -: 8]; // RULE5
      end else if (index >= inq_verify_pkg::PRODUCT_FIRST &&
                   index < inq_verify_pkg::REVISION_FIRST) begin
         dataByte = PRODUCT_TEXT[8'(127 - 8 * prodOff) -: 8]; // RULE6
      end else if (index == inq_verify_pkg::REVISION_FIRST) begin
         dataByte = inq_verify_pkg::ASCII_DASH; // RULE7
      end else if (index > inq_verify_pkg::REVISION_FIRST &&
                   index <= inq_verify_pkg::INQ_LAST) begin
         dataByte = REVISION_DIGITS[8'(23 - 8 * (revOff - 5'd1)) -: 8]; // RULE7
      end
   end
endmodule // inquiry_rom

// ==== rtl/scsi_inquiry_verify_target.sv ====
// Target-side inquiry and verify command engine
// Notes on behaviour
// RULE1 - Byte 2 bits 3..5 carry zero: no European standard claim.
// RULE2 - Byte 2 bits 0..2 carry one: the 1986 bus standard version.
// RULE3 - Byte 4 reports 31 further bytes, starting at offset 05h.
// RULE4 - Extra-byte count stays 31 whatever the allocation length.
// RULE5 - Bytes 8..15 hold an eight-character ASCII maker name, space padded.
// RULE6 - Bytes 16..31 hold a sixteen-character ASCII product string.
// RULE7 - Bytes 32..35 hold a dash and three firmware revision digits.
// RULE8 - Good inquiry returns status 00h, no tape motion, modes kept.
// RULE9 - Parity error gives status 02h and sense key 04h.
// RULE10 - Invalid command bit gives check status with sense key 05h.
// RULE11 - Opcode 13h checks block CRCs, no bus data, no tape writes.
// RULE12 - Verify stops at count, filemark, end of tape or bad CRC.
// RULE13 - Tape is left just past last verified block or filemark; on end of tape or bad CRC the code leaves it past that failing block.
// RULE14 - Zero block count checks nothing, no motion, good status.
// RULE15 - Byte 1 bit 1 must be clear for CRC checking.
// RULE16 - Byte 1 bit 0 must be set for fixed-size blocks.
// RULE17 - Bytes 2..4 hold the 24-bit block count, most significant first.
// RULE18 - Send allocation length bytes, at most 36; zero sends none.
// RULE19 - Bad verify byte 1 bits give illegal request, no tape motion.
`timescale 1ns/1ps
module scsi_inquiry_verify_target #(
   parameter logic [63:0] VENDOR_TEXT = 64'h5441_5045_4455_5620,
   parameter logic [127:0] PRODUCT_TEXT = 128'h5441_5045_2D44_5249_5645_2031_3233_3435,
   parameter logic [23:0] REVISION_DIGITS = 24'h303031
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire inq_verify_pkg::cdb_type cmdBlock,
   input wire logic cmdParityError,
   input wire logic driveParityError,
   output logic dataValid,
   input wire logic dataReady,
   output logic [7:0] dataByte,
   output logic dataLast,
   output logic blockReadReq,
   input wire logic blockResultValid,
   input wire inq_verify_pkg::block_result_type blockResult,
   output logic doneValid,
   output inq_verify_pkg::completion_type doneInfo,
   output logic [23:0] blocksVerified,
   output logic busy
);
   typedef enum logic [2:0] {
      IDLE,
      SEND,
      VREQ,
      VWAIT,
      DONE
   } state_type;

   state_type state_ff;
   logic [5:0] index_ff;
   logic [5:0] sendLen_ff;
   logic [23:0] remain_ff;
   logic [23:0] verified_ff;
   inq_verify_pkg::completion_type result_ff;
   logic [7:0] dataByte_ff;
   logic [5:0] nxt_index;
   logic [7:0] romByte;
   logic [5:0] allocLen;
   logic cdbBadVerify;
   logic cdbZeroCount;
   logic [23:0] cdbCount;
   logic sendStep;
   logic anyParity;

   inquiry_rom #(
      .VENDOR_TEXT(VENDOR_TEXT),
      .PRODUCT_TEXT(PRODUCT_TEXT),
      .REVISION_DIGITS(REVISION_DIGITS)
   ) u_rom (
      .index(nxt_index),
      .dataByte(romByte)
   );

   // Command decode
   always_comb begin
      cdbCount = {cmdBlock.byte2, cmdBlock.byte3, cmdBlock.byte4}; // RULE17
      cdbBadVerify = cmdBlock.byte1[inq_verify_pkg::BYTE_COMPARE_BIT] ||
                     !cmdBlock.byte1[inq_verify_pkg::FIXED_BLOCK_BIT]; // RULE15 RULE16 RULE19
      cdbZeroCount = (cdbCount == inq_verify_pkg::COUNT_RESET); // RULE14
      if (cmdBlock.byte4 > 8'(inq_verify_pkg::INQ_MAX_LEN)) begin
         allocLen = inq_verify_pkg::INQ_MAX_LEN; // RULE18
      end else begin
         allocLen = cmdBlock.byte4[5:0];
      end
      anyParity = cmdParityError || driveParityError;
   end

   assign cmdReady = (state_ff == IDLE);
   assign busy = (state_ff != IDLE);
   assign sendStep = (state_ff == SEND) && dataReady;
   assign dataValid = (state_ff == SEND);
   assign dataByte = dataByte_ff;
   assign dataLast = (state_ff == SEND) && (index_ff == 6'(sendLen_ff - 6'd1));
   assign blockReadReq = (state_ff == VREQ); // RULE11
   assign doneValid = (state_ff == DONE);
   assign doneInfo = result_ff;
   assign blocksVerified = verified_ff;

   always_comb begin
      nxt_index = index_ff;
      if (state_ff == IDLE) begin
         nxt_index = 6'd0;
      end else if (sendStep) begin
         nxt_index = 6'(index_ff + 6'd1);
      end
   end

   // Main sequence
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= IDLE;
      end else begin
         unique case (state_ff)
            IDLE: begin
               if (cmdValid) begin
                  if (anyParity) begin
                     state_ff <= DONE; // RULE9
                  end else if (cmdBlock.opcode == inq_verify_pkg::OP_INQUIRY) begin
                     state_ff <= (allocLen == 6'd0) ? DONE : SEND; // RULE18
                  end else if (cmdBlock.opcode == inq_verify_pkg::OP_VERIFY) begin
                     state_ff <= (cdbBadVerify || cdbZeroCount) ? DONE : VREQ; // RULE14 RULE19
                  end else begin
                     state_ff <= DONE; // RULE10
                  end
               end
            end
            SEND: begin
               if (driveParityError) begin
                  state_ff <= DONE; // RULE9
               end else if (sendStep && index_ff == 6'(sendLen_ff - 6'd1)) begin
                  state_ff <= DONE;
               end
            end
            VREQ: begin
               state_ff <= VWAIT;
            end
            VWAIT: begin
               if (driveParityError) begin
                  state_ff <= DONE; // RULE9
               end else if (blockResultValid) begin
                  if (blockResult.crcGood && !blockResult.filemark &&
                      !blockResult.endOfTape && remain_ff != 24'd1) begin
                     state_ff <= VREQ;
                  end else begin
                     state_ff <= DONE; // RULE12
                  end
               end
            end
            DONE: begin
               state_ff <= IDLE;
            end
         endcase
      end
   end

   // Inquiry byte pointer and output byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         index_ff <= 6'd0;
         sendLen_ff <= 6'd0;
         dataByte_ff <= 8'h00;
      end else begin
         index_ff <= nxt_index;
         if (state_ff == IDLE) begin
            sendLen_ff <= allocLen; // RULE18
         end
         dataByte_ff <= romByte;
      end
   end

   // Verify counters
   always_ff @(posedge mclk) begin
      if (rst) begin
         remain_ff <= inq_verify_pkg::COUNT_RESET;
         verified_ff <= inq_verify_pkg::COUNT_RESET;
      end else if (state_ff == IDLE && cmdValid) begin
         remain_ff <= cdbCount; // RULE17
         verified_ff <= inq_verify_pkg::COUNT_RESET;
      end else if (state_ff == VWAIT && blockResultValid && blockResult.crcGood &&
                   !blockResult.filemark && !blockResult.endOfTape) begin
         remain_ff <= 24'(remain_ff - 24'd1); // RULE12
         verified_ff <= 24'(verified_ff + 24'd1); // RULE13
      end
   end

   // Completion status
   always_ff @(posedge mclk) begin
      if (rst) begin
         result_ff <= '{inq_verify_pkg::STATUS_GOOD, inq_verify_pkg::SENSE_NONE,
                        inq_verify_pkg::SENSE_FLAGS_NONE};
      end else if (state_ff == IDLE && cmdValid) begin
         if (anyParity) begin
            result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_HARDWARE,
                           inq_verify_pkg::SENSE_FLAGS_NONE}; // RULE9
         end else if (cmdBlock.opcode == inq_verify_pkg::OP_INQUIRY ||
                      (cmdBlock.opcode == inq_verify_pkg::OP_VERIFY && !cdbBadVerify)) begin
            result_ff <= '{inq_verify_pkg::STATUS_GOOD, inq_verify_pkg::SENSE_NONE,
                           inq_verify_pkg::SENSE_FLAGS_NONE}; // RULE8 RULE14
         end else begin
            result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_ILLEGAL,
                           inq_verify_pkg::SENSE_FLAGS_NONE}; // RULE10 RULE19
         end
      end else if ((state_ff == SEND || state_ff == VWAIT) && driveParityError) begin
         result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_HARDWARE,
                        inq_verify_pkg::SENSE_FLAGS_NONE}; // RULE9
      end else if (state_ff == VWAIT && blockResultValid) begin
         if (blockResult.filemark) begin
            result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_NONE,
                           inq_verify_pkg::SENSE_FLAGS_FILEMARK}; // RULE12 RULE13
         end else if (blockResult.endOfTape) begin
            result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_NONE,
                           inq_verify_pkg::SENSE_FLAGS_EOT}; // RULE12
         end else if (blockResult.crcBad || !blockResult.crcGood) begin
            result_ff <= '{inq_verify_pkg::STATUS_CHECK, inq_verify_pkg::SENSE_MEDIA,
                           inq_verify_pkg::SENSE_FLAGS_NONE}; // RULE12
         end
      end
   end
endmodule // scsi_inquiry_verify_target

// ==== test/tape_model.sv ====
// Tape medium model answering block read requests
`timescale 1ns/1ps
module tape_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic blockReadReq,
   input wire logic [11:0] stopAt,
   input wire inq_verify_pkg::block_result_type stopKind,
   output logic blockResultValid,
   output inq_verify_pkg::block_result_type blockResult,
   output logic [11:0] position
);
   logic [1:0] pend_ff;
   logic [11:0] cur_ff;
   logic [3:0] noise_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pend_ff <= 2'h0;
         position <= 12'h000;
      end else begin
         pend_ff <= {pend_ff[0], blockReadReq};
         if (blockReadReq) position <= position + 12'h001;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_ff <= 12'h000;
         noise_ff <= 4'h0;
      end else begin
         if (blockReadReq) cur_ff <= position;
         noise_ff <= noise_ff + 4'h5;
      end
   end
   assign blockResultValid = pend_ff[1];
   // Stop condition at chosen block, noise while idle
   assign blockResult = !pend_ff[1] ? noise_ff : (cur_ff == stopAt ? stopKind : 4'h8);
endmodule // tape_model

// ==== test/scsi_inquiry_verify_target_checker.sv ====
// Assertion checker for the inquiry and verify engine
`timescale 1ns/1ps
module scsi_inquiry_verify_target_checker (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire inq_verify_pkg::cdb_type cmdBlock,
   input wire logic cmdParityError,
   input wire logic dataValid,
   input wire logic dataReady,
   input wire logic [7:0] dataByte,
   input wire logic blockReadReq,
   input wire logic doneValid,
   input wire inq_verify_pkg::completion_type doneInfo,
   input wire logic busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic take, vfy, okBits, zero;
   assign take = cmdValid && cmdReady;
   assign vfy = take && !cmdParityError && cmdBlock.opcode == inq_verify_pkg::OP_VERIFY;
   assign okBits = cmdBlock.byte1[1:0] == 2'h1;
   assign zero = {cmdBlock.byte2, cmdBlock.byte3, cmdBlock.byte4} == 24'h000000;
   chk_ready_not_busy: assert property (busy |-> !cmdReady) else $error("ready while busy");
   chk_byte_holds: assert property (dataValid && !dataReady |=> dataValid && $stable(dataByte))
      else $error("byte dropped");
   chk_done_pulse: assert property (doneValid |=> !doneValid) else $error("done too long");
   chk_verify_starts: assert property (vfy && okBits && !zero |=> blockReadReq)
      else $error("no block request");
   chk_bad_bits: assert property (vfy && !okBits |=> doneValid && !blockReadReq
      && doneInfo.senseKey == inq_verify_pkg::SENSE_ILLEGAL) else $error("bad bits taken");
   chk_parity_check: assert property (take && cmdParityError |=> doneValid
      && doneInfo.status == 8'h02 && doneInfo.senseKey == 4'h4) else $error("parity status");
   chk_zero_count: assert property (vfy && okBits && zero |=> doneValid
      && !blockReadReq && doneInfo.status == 8'h00) else $error("zero count");
   chk_no_bus_data: assert property (blockReadReq |-> !dataValid) else $error("data in verify");
   chk_inquiry_data: assert property (take && !cmdParityError && cmdBlock.opcode == 8'h12
      && cmdBlock.byte4 != 8'h00 |=> dataValid) else $error("no inquiry data");
   cov_inquiry: cover property (dataValid && dataReady);
   cov_verify: cover property (blockReadReq);
   cov_check: cover property (doneValid && doneInfo.status == 8'h02);
endmodule // scsi_inquiry_verify_target_checker
bind scsi_inquiry_verify_target scsi_inquiry_verify_target_checker chk (.mclk(mclk), .rst(rst),
   .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdBlock(cmdBlock),
   .cmdParityError(cmdParityError), .dataValid(dataValid), .dataReady(dataReady),
   .dataByte(dataByte), .blockReadReq(blockReadReq), .doneValid(doneValid),
   .doneInfo(doneInfo), .busy(busy));

// ==== test/scsi_inquiry_verify_target_tb.sv ====
// Self-checking bench for the inquiry and verify engine
`timescale 1ns/1ps
module scsi_inquiry_verify_target_tb;
   // Arbitrary identification text
   localparam logic [63:0] V = 64'h4D41_4B45_5251_2020;
   localparam logic [127:0] P = 128'h5441_5045_2055_4E49_5420_3132_3334_3536;
   localparam logic [23:0] R = 24'h303037;
   logic mclk, rst, cmdValid, cmdReady, cmdParityError, driveParityError, dataValid, dataReady;
   logic dataLast, blockReadReq, blockResultValid, doneValid, busy;
   inq_verify_pkg::cdb_type cmdBlock;
   inq_verify_pkg::block_result_type blockResult, stopKind;
   inq_verify_pkg::completion_type doneInfo;
   logic [7:0] dataByte;
   logic [23:0] blocksVerified;
   logic [11:0] stopAt, position, pos0;
   logic [31:0] seed = 32'h0000_0037;
   logic [3:0] kinds [3] = '{4'h2, 4'h1, 4'h4};
   logic [7:0] b1s [3] = '{8'h00, 8'h02, 8'h03};
   int bad_count = 0, n_compared = 0, cycles = 0;
   always #5 mclk = ~mclk;
   scsi_inquiry_verify_target #(.VENDOR_TEXT(V), .PRODUCT_TEXT(P), .REVISION_DIGITS(R)) uut (
      .mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdBlock(cmdBlock),
      .cmdParityError(cmdParityError), .driveParityError(driveParityError),
      .dataValid(dataValid), .dataReady(dataReady), .dataByte(dataByte), .dataLast(dataLast),
      .blockReadReq(blockReadReq), .blockResultValid(blockResultValid),
      .blockResult(blockResult), .doneValid(doneValid), .doneInfo(doneInfo),
      .blocksVerified(blocksVerified), .busy(busy));
   tape_model tape (.mclk(mclk), .rst(rst), .blockReadReq(blockReadReq), .stopAt(stopAt),
      .stopKind(stopKind), .blockResultValid(blockResultValid), .blockResult(blockResult),
      .position(position));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [7:0] inqByte(int k);
      if (k >= 33) return R[8*(35-k) +: 8];
      if (k == 32) return 8'h2D;
      if (k >= 16) return P[8*(31-k) +: 8];
      if (k >= 8) return V[8*(15-k) +: 8];
      if (k == 4) return 8'h1F;
      if (k == 1) return 8'h80;
      return (k == 0 || k == 2) ? 8'h01 : 8'h00;
   endfunction
   task chk(string nm, logic [23:0] e, logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task send(logic [7:0] op, logic [7:0] b1, logic [23:0] b24, logic par);
      @(negedge mclk);
      cmdBlock = {op, b1, b24, 8'h00};
      cmdParityError = par;
      cmdValid = 1;
      while (cmdReady !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      cmdValid = 0;
      cmdParityError = 0;
   endtask
   task done(logic [7:0] st, logic [3:0] k, logic [7:0] f);
      int i;
      for (i = 0; i < 2000 && doneValid !== 1'b1; i++) @(negedge mclk);
      chk("done", 1, doneValid);
      chk("status", st, doneInfo.status);
      chk("sense key", k, doneInfo.senseKey);
      chk("sense flags", f, doneInfo.senseFlags);
      $display("test ended, status %h", doneInfo.status);
   endtask
   task inquiry(logic [7:0] alloc);
      int n, k, g;
      logic [11:0] p0;
      p0 = position;
      n = alloc > 36 ? 36 : alloc;
      k = 0;
      send(8'h12, 8'h00, {16'h0000, alloc}, 0);
      for (g = 0; g < 400 && doneValid !== 1'b1; g++) begin
         dataReady = rnd() % 2;
         if (dataValid === 1'b1 && dataReady) begin
            chk("data byte", inqByte(k), dataByte);
            chk("last", k == n - 1, dataLast);
            k++;
         end
         @(negedge mclk);
      end
      dataReady = 0;
      chk("byte count", n, k);
      done(8'h00, 4'h0, 8'h00);
      chk("inquiry position", 24'(p0), 24'(position));
   endtask
   task verify(logic [23:0] cnt, int s, logic [3:0] kind, logic dpe);
      logic [11:0] p0;
      logic stops;
      p0 = position;
      stopAt = p0 + 12'(s);
      stopKind = kind;
      stops = s < cnt;
      send(8'h13, 8'h01, cnt, 0);
      driveParityError = dpe;
      if (dpe) done(8'h02, 4'h4, 8'h00);
      else begin
         done(stops ? 8'h02 : 8'h00, kind[2] && stops ? 4'h3 : 4'h0, !stops ? 8'h00 :
            kind[1] ? 8'h80 : kind[0] ? 8'h40 : 8'h00);
         chk("verified", stops ? s : cnt, blocksVerified);
         chk("position", 24'(p0) + (stops ? s + 1 : cnt), 24'(position));
      end
      driveParityError = 0;
   endtask
   task print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      mclk = 0;
      rst = 1;
      cmdValid = 0;
      cmdBlock = '0;
      cmdParityError = 0;
      driveParityError = 0;
      dataReady = 0;
      stopAt = 12'h000;
      stopKind = 4'h8;
      repeat (8) @(posedge mclk);
      @(negedge mclk) rst = 0;
      foreach (b1s[i]) inquiry(8'(i * 18 + 1));
      inquiry(8'h00);
      inquiry(8'h24);
      inquiry(8'hFF);
      repeat (3) inquiry(8'(rnd()));
      verify(24'h000000, 4000, 4'h8, 0);
      verify(24'h000100, 4000, 4'h8, 0);
      repeat (8) verify(24'(rnd() % 6 + 1), rnd() % 8, kinds[rnd() % 3], 0);
      verify(24'h000005, 4000, 4'h8, 1);
      foreach (b1s[i]) begin
         pos0 = position;
         send(8'h13, b1s[i], 24'h000004, 0);
         done(8'h02, 4'h5, 8'h00);
         chk("rejected position", 24'(pos0), 24'(position));
      end
      send(8'h12, 8'h00, 24'h000024, 1);
      done(8'h02, 4'h4, 8'h00);
      send(8'h1A, 8'h00, 24'h000000, 0);
      done(8'h02, 4'h5, 8'h00);
      print_verdict();
   end
endmodule // scsi_inquiry_verify_target_tb
